// ---- i2c_regport_pkg.sv ----
// constants, types and states shared by the two-wire register port
package i2c_regport_pkg;

    // ********************************
    // register bank
    // ********************************
    localparam int NUM_REGS = 8;
    localparam int PTR_W = 3;
    localparam int CFG_W = 64;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [2:0] STAT_REG = 3'h7;
    localparam int STAT_BIT = 7;

    // ********************************
    // slave address a6..a3, id bit, a1..a0
    // ********************************
    localparam logic [3:0] DEV_ADDR_HI = 4'hb;
    localparam logic [1:0] DEV_ADDR_LO = 2'h0;

    // ********************************
    // bit counting
    // ********************************
    localparam logic [3:0] BYTE_END = 4'h8;
    localparam logic [3:0] TX_LAST = 4'h7;

    // ********************************
    // sampled pins and protocol states
    // ********************************
    typedef struct packed {
        logic scl;
        logic sda;
        logic id;
        logic lock;
    } pin_s;

    localparam pin_s PIN_IDLE = '{scl: 1'b1, sda: 1'b1, id: 1'b0, lock: 1'b0};

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_AACK = 7'h04,
        ST_RX = 7'h08,
        ST_RACK = 7'h10,
        ST_TX = 7'h20,
        ST_MACK = 7'h40
    } state_e;

endpackage

// ---- i2c_slave_register_port.sv ----
// two-wire slave giving a bus master access to eight byte registers
`timescale 1ns/1ps

module i2c_slave_register_port
    import i2c_regport_pkg::*;
(
    input wire logic i_clk,               // core clock
    input wire logic i_rstn,              // async reset, active low
    input wire logic i_link_clk,          // interface clock, free of the oscillator
    input wire logic i_scl,               // serial clock pin
    input wire logic i_sda_in,            // serial data pin level
    input wire logic i_id_sel,            // bus-id select pin
    input wire logic i_lock_flag,         // live loop lock flag, core domain
    output logic o_sda_out,               // serial data drive value
    output logic o_sda_oe,                // serial data drive enable
    output logic [CFG_W-1:0] o_cfg        // register contents, core domain
);

    // ************************************************
    // helpers
    // ************************************************
    function automatic logic addr_hit(input logic [6:0] a, input logic id);
        addr_hit = (a == {DEV_ADDR_HI, id, DEV_ADDR_LO});
    endfunction

    function automatic logic [7:0] rd_byte(input logic [7:0] r, input logic [PTR_W-1:0] idx,
                                           input logic flag);
        rd_byte = r;
        if (idx == STAT_REG) begin
            rd_byte[STAT_BIT] = flag;
        end
    endfunction

    // ************************************************
    // pin synchronisers and filter (link domain)
    // ************************************************
    pin_s sync1, sync2, sync3, filt, prev;
    pin_s next_filt;

    always_comb begin
        next_filt = filt;
        if (sync2.scl == sync3.scl) next_filt.scl = sync3.scl;
        if (sync2.sda == sync3.sda) next_filt.sda = sync3.sda;
        if (sync2.id == sync3.id) next_filt.id = sync3.id;
        if (sync2.lock == sync3.lock) next_filt.lock = sync3.lock;
    end

    always_ff @(posedge i_link_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync1 <= PIN_IDLE;
            sync2 <= PIN_IDLE;
            sync3 <= PIN_IDLE;
            filt <= PIN_IDLE;
            prev <= PIN_IDLE;
        end else begin
            sync1 <= '{scl: i_scl, sda: i_sda_in, id: i_id_sel, lock: i_lock_flag};
            sync2 <= sync1;
            sync3 <= sync2;
            filt <= next_filt;
            prev <= filt;
        end
    end

    logic scl_rise, scl_fall, start, stop;
    assign scl_rise = filt.scl & ~prev.scl;
    assign scl_fall = ~filt.scl & prev.scl;
    assign start = filt.scl & prev.scl & prev.sda & ~filt.sda;
    assign stop = filt.scl & prev.scl & ~prev.sda & filt.sda;

    // ************************************************
    // protocol engine and register bank (link domain)
    // ************************************************
    state_e state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [7:0] shreg, next_sh;
    logic got_ptr, next_got, rw, next_rw, mack, next_mack, sda_oe, next_oe, commit;
    logic [PTR_W-1:0] ptr, next_ptr;
    logic [7:0] regs [NUM_REGS];
    logic [7:0] next_regs [NUM_REGS];
    logic [7:0] fetch;

    assign fetch = rd_byte(regs[ptr], ptr, filt.lock);

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_sh = shreg;
        next_got = got_ptr;
        next_rw = rw;
        next_mack = mack;
        next_ptr = ptr;
        next_regs = regs;
        next_oe = sda_oe;
        commit = 1'b0;
        if (stop) begin
            next_state = ST_IDLE;
            next_oe = 1'b0;
        end else if (start) begin
            next_state = ST_ADDR;
            next_cnt = 4'h0;
            next_oe = 1'b0;
            next_got = 1'b0;
        end else begin
            case (state)
                ST_ADDR: begin
                    if (scl_rise) begin
                        next_sh = {shreg[6:0], filt.sda};
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall && cnt == BYTE_END) begin
                        if (addr_hit(shreg[7:1], filt.id)) begin
                            next_oe = 1'b1;
                            next_rw = shreg[0];
                            next_state = ST_AACK;
                        end else begin
                            next_state = ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        next_cnt = 4'h0;
                        if (rw) begin
                            next_sh = fetch;
                            next_oe = ~fetch[7];
                            next_state = ST_TX;
                        end else begin
                            next_oe = 1'b0;
                            next_state = ST_RX;
                        end
                    end
                end
                ST_RX: begin
                    if (scl_rise) begin
                        next_sh = {shreg[6:0], filt.sda};
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall && cnt == BYTE_END) begin
                        next_oe = 1'b1;
                        next_state = ST_RACK;
                        if (got_ptr) begin
                            next_regs[ptr] = shreg;
                            next_ptr = ptr + 3'h1;
                            commit = 1'b1;
                        end else begin
                            next_ptr = shreg[PTR_W-1:0];
                            next_got = 1'b1;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_fall) begin
                        next_oe = 1'b0;
                        next_cnt = 4'h0;
                        next_state = ST_RX;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (cnt == TX_LAST) begin
                            next_oe = 1'b0;
                            next_ptr = ptr + 3'h1;
                            next_state = ST_MACK;
                        end else begin
                            next_cnt = cnt + 4'h1;
                            next_sh = {shreg[6:0], 1'b0};
                            next_oe = ~shreg[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        next_mack = ~filt.sda;
                    end else if (scl_fall) begin
                        if (mack) begin
                            next_cnt = 4'h0;
                            next_sh = fetch;
                            next_oe = ~fetch[7];
                            next_state = ST_TX;
                        end else begin
                            next_state = ST_IDLE;
                        end
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_link_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= ST_IDLE;
            cnt <= 4'h0;
            shreg <= 8'h00;
            got_ptr <= 1'b0;
            rw <= 1'b0;
            mack <= 1'b0;
            ptr <= 3'h0;
            sda_oe <= 1'b0;
            for (int i = 0; i < NUM_REGS; i++) begin
                regs[i] <= REG_RESET;
            end
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            shreg <= next_sh;
            got_ptr <= next_got;
            rw <= next_rw;
            mack <= next_mack;
            ptr <= next_ptr;
            sda_oe <= next_oe;
            regs <= next_regs;
        end
    end

    // ************************************************
    // register snapshot handed to the core domain
    // ************************************************
    logic pend, next_pend, req, next_req, ack_s1, ack_s2;
    logic req_s1, req_s2, ack_l, next_ack;
    logic [CFG_W-1:0] snap, next_snap;

    always_comb begin
        next_pend = pend;
        next_req = req;
        next_snap = snap;
        if (pend && req == ack_s2) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                next_snap[i*8 +: 8] = regs[i];
            end
            next_req = ~req;
            next_pend = 1'b0;
        end
        if (commit) next_pend = 1'b1;
    end

    always_ff @(posedge i_link_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pend <= 1'b0;
            req <= 1'b0;
            snap <= '0;
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end else begin
            pend <= next_pend;
            req <= next_req;
            snap <= next_snap;
            ack_s1 <= ack_l;
            ack_s2 <= ack_s1;
        end
    end

    // ************************************************
    // core domain capture
    // ************************************************
    logic [CFG_W-1:0] cfg, next_cfg;

    always_comb begin
        next_ack = ack_l;
        next_cfg = cfg;
        if (req_s2 != ack_l) begin
            next_cfg = snap;
            next_ack = req_s2;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            ack_l <= 1'b0;
            cfg <= '0;
        end else begin
            req_s1 <= req;
            req_s2 <= req_s1;
            ack_l <= next_ack;
            cfg <= next_cfg;
        end
    end

    assign o_sda_oe = sda_oe;
    assign o_sda_out = 1'b0;
    assign o_cfg = cfg;

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge i_link_clk); endclocking
    default disable iff (!i_rstn);

    a_gcall_ignored: assert property (state == ST_ADDR && scl_fall && cnt == BYTE_END && !start
        && !stop && shreg[7:1] == 7'h00 |=> !sda_oe && state == ST_IDLE)
        else $error("general call answered");
    a_start_seen: assert property (start && !stop |=> state == ST_ADDR && !sda_oe)
        else $error("start not taken");
    a_addr_match: assert property (state == ST_ADDR && scl_fall && cnt == BYTE_END && !start
        && !stop && shreg[7:1] == {DEV_ADDR_HI, filt.id, DEV_ADDR_LO}
        |=> sda_oe && state == ST_AACK)
        else $error("own address not acknowledged");
    a_ptr_load: assert property (state == ST_RX && scl_fall && cnt == BYTE_END && !got_ptr
        && !start && !stop |=> ptr == $past(shreg[2:0]) && got_ptr)
        else $error("pointer not loaded");
    a_ack_held: assert property ((state == ST_RACK || state == ST_AACK) |-> sda_oe)
        else $error("acknowledge released early");
    a_nack_release: assert property (state == ST_MACK && scl_fall && !mack && !start && !stop
        |=> !sda_oe && state == ST_IDLE)
        else $error("sda held after nack");
    a_stop_idle: assert property (stop |=> (state == ST_IDLE && !sda_oe) [*2])
        else $error("stop not honoured");
    a_commit_wrap: assert property (state == ST_RX && scl_fall && cnt == BYTE_END && got_ptr
        && !start && !stop |=> regs[$past(ptr)] == $past(shreg)
        && ptr == $past(ptr) + 3'h1)
        else $error("write not committed");
    a_rd_incr: assert property (state == ST_TX && scl_fall && cnt == TX_LAST && !start && !stop
        |=> ptr == $past(ptr) + 3'h1 && state == ST_MACK)
        else $error("read pointer not advanced");
    a_tx_stable: assert property (state == ST_TX && !scl_fall && !start && !stop
        |=> $stable(sda_oe))
        else $error("sda moved outside scl low");

    c_write: cover property (commit);
    c_read_more: cover property (state == ST_MACK && scl_fall && mack);
    c_read_end: cover property (state == ST_MACK && scl_fall && !mack);

endmodule

// ---- i2c_bus_master_model.sv ----
// behavioural two-wire bus master facing the register port
`timescale 1ns/1ps

module i2c_bus_master_model #(
    parameter int HALF = 40
) (
    input wire logic i_clk,    // pacing clock
    input wire logic i_sda,    // resolved data wire
    output logic o_scl,        // serial clock, pulled up when idle
    output logic o_pull        // high pulls the data wire low
);
    initial begin
        o_scl = 1'b1;
        o_pull = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // ********************************
    // bus conditions
    // ********************************
    // start from idle, or repeated start from a low clock phase
    task automatic send_start();
        wait_clk(HALF / 4);
        o_pull <= 1'b0;
        wait_clk(HALF);
        o_scl <= 1'b1;
        wait_clk(HALF);
        o_pull <= 1'b1;
        wait_clk(HALF);
        o_scl <= 1'b0;
        wait_clk(HALF);
    endtask

    task automatic send_stop();
        wait_clk(HALF / 4);
        o_pull <= 1'b1;
        wait_clk(HALF);
        o_scl <= 1'b1;
        wait_clk(HALF);
        o_pull <= 1'b0;
        wait_clk(HALF);
    endtask

    // ********************************
    // bits and bytes
    // ********************************
    // data moves a quarter phase after the clock falls, sampled mid-high
    task automatic clock_bit(input logic b, output logic r);
        wait_clk(HALF / 4);
        o_pull <= ~b;
        wait_clk(HALF);
        o_scl <= 1'b1;
        wait_clk(HALF / 2);
        r = i_sda;
        wait_clk(HALF / 2);
        o_scl <= 1'b0;
    endtask

    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) clock_bit(d[i], r);
        clock_bit(1'b1, r);
        ack = ~r;
    endtask

    task automatic read_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, r);
            d[i] = r;
        end
        // acknowledge by pulling low, leave the wire released after the last byte
        clock_bit(last, r);
    endtask
endmodule

// ---- i2c_slave_register_port_test.sv ----
// self-checking bench for the two-wire register port
`timescale 1ns/1ps

module i2c_slave_register_port_test import i2c_regport_pkg::*;;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rstn, id_sel, lock_flag, sda_out, sda_oe, scl, pull, sda;
    logic [CFG_W-1:0] cfg;
    logic [7:0] exp_reg [NUM_REGS];
    int n_mismatch, compares;

    // open-drain wire with pull-up
    assign sda = (pull || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

    always #2 clk = ~clk;
    initial begin
        #1.7;
        forever #6 link_clk = ~link_clk;
    end

    i2c_slave_register_port i2c_slave_register_port_inst (.i_clk(clk), .i_rstn(rstn),
        .i_link_clk(link_clk), .i_scl(scl), .i_sda_in(sda), .i_id_sel(id_sel),
        .i_lock_flag(lock_flag), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_cfg(cfg));
    i2c_bus_master_model i2c_bus_master_model_inst (.i_clk(clk), .i_sda(sda),
        .o_scl(scl), .o_pull(pull));

    // ********************************
    // helpers
    // ********************************
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] addr_byte(input logic rw);
        return {DEV_ADDR_HI, id_sel, DEV_ADDR_LO, rw};
    endfunction

    function automatic logic [63:0] bank();
        logic [63:0] p;
        for (int i = 0; i < NUM_REGS; i++) p[8*i +: 8] = exp_reg[i];
        return p;
    endfunction

    task automatic open_write(input logic [7:0] ptr);
        logic a;
        i2c_bus_master_model_inst.send_start();
        i2c_bus_master_model_inst.write_byte(addr_byte(1'b0), a);
        chk(64'(a), 64'h1);
        i2c_bus_master_model_inst.write_byte(ptr, a);
        chk(64'(a), 64'h1);
    endtask

    task automatic complete_run();
        if (n_mismatch == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ********************************
    // scenarios
    // ********************************
    task automatic t_reset();
        chk(cfg, 64'h0);
        chk(64'(sda_oe), 64'h0);
    endtask

    // ten bytes from pointer 6 wrap round the bank, checked before stop
    task automatic t_seq_write();
        logic a;
        logic [7:0] d;
        open_write(8'h06);
        for (int k = 0; k < 10; k++) begin
            d = 8'h21 * 8'(k + 1);
            i2c_bus_master_model_inst.write_byte(d, a);
            chk(64'(a), 64'h1);
            exp_reg[3'(6 + k)] = d;
        end
        repeat (40) @(posedge clk);
        chk(cfg, bank());
        i2c_bus_master_model_inst.send_stop();
    endtask

    task automatic t_foreign();
        logic a;
        logic [7:0] bad [3];
        bad[0] = 8'h00;
        bad[1] = addr_byte(1'b0) ^ 8'h04;
        bad[2] = addr_byte(1'b0) ^ 8'h80;
        for (int i = 0; i < 3; i++) begin
            i2c_bus_master_model_inst.send_start();
            i2c_bus_master_model_inst.write_byte(bad[i], a);
            chk(64'(a), 64'h0);
            i2c_bus_master_model_inst.write_byte(8'hff, a);
            chk(64'(a), 64'h0);
            i2c_bus_master_model_inst.send_stop();
        end
        chk(cfg, bank());
    endtask

    // id pin high moves the address; pointer upper bits ignored
    task automatic t_id_select();
        logic a;
        id_sel <= 1'b1;
        repeat (20) @(posedge clk);
        open_write(8'hf9);
        i2c_bus_master_model_inst.write_byte(8'h5a, a);
        chk(64'(a), 64'h1);
        exp_reg[1] = 8'h5a;
        i2c_bus_master_model_inst.send_stop();
        repeat (40) @(posedge clk);
        chk(cfg, bank());
        id_sel <= 1'b0;
        repeat (20) @(posedge clk);
    endtask

    task automatic t_abort();
        logic r;
        open_write(8'h02);
        for (int i = 0; i < 4; i++) i2c_bus_master_model_inst.clock_bit(1'b0, r);
        i2c_bus_master_model_inst.send_stop();
        open_write(8'h03);
        for (int i = 0; i < 5; i++) i2c_bus_master_model_inst.clock_bit(1'b1, r);
        i2c_bus_master_model_inst.send_start();
        i2c_bus_master_model_inst.send_stop();
        repeat (40) @(posedge clk);
        chk(cfg, bank());
    endtask

    // read all eight from pointer 3 with the live flag set
    task automatic t_seq_read();
        logic a;
        logic [7:0] d, e;
        lock_flag <= 1'b1;
        open_write(8'h03);
        i2c_bus_master_model_inst.send_start();
        i2c_bus_master_model_inst.write_byte(addr_byte(1'b1), a);
        chk(64'(a), 64'h1);
        for (int k = 0; k < NUM_REGS; k++) begin
            i2c_bus_master_model_inst.read_byte(k == NUM_REGS - 1, d);
            e = exp_reg[3'(3 + k)];
            if (3'(3 + k) == STAT_REG) begin
                e[STAT_BIT] = 1'b1;
            end
            chk(64'(d), 64'(e));
        end
        repeat (30) @(posedge clk);
        chk(64'(sda_oe), 64'h0);
        i2c_bus_master_model_inst.send_stop();
    endtask

    // ********************************
    // main sequence
    // ********************************
    initial begin
        rstn = 1'b0;
        id_sel = 1'b0;
        lock_flag = 1'b0;
        n_mismatch = 0;
        compares = 0;
        for (int i = 0; i < NUM_REGS; i++) exp_reg[i] = REG_RESET;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (20) @(posedge clk);
        t_reset();
        t_seq_write();
        t_foreign();
        t_id_select();
        t_abort();
        t_seq_read();
        complete_run();
    end

    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end
endmodule
